// ==== verilog/mhp_pkg.sv ====
// Constants and types shared by both ends of the mixer host port
package mhp_pkg;

  // ----------------------------------------------------------------
  // Port addresses on the three address pins
  // ----------------------------------------------------------------
  localparam logic [2:0] PA_WR_PTR = 3'h0;
  localparam logic [2:0] PA_RAM_DATA = 3'h1;
  localparam logic [2:0] PA_RSVD_TWO = 3'h2;
  localparam logic [2:0] PA_RD_PTR = 3'h3;
  localparam logic [2:0] PA_RSVD_FOUR = 3'h4;
  localparam logic [2:0] PA_CTL_DATA = 3'h5;
  localparam logic [2:0] PA_PIXEL_MASK = 3'h6;
  localparam logic [2:0] PA_INDIRECT_SEL = 3'h7;

  // ----------------------------------------------------------------
  // Indirect select fields and RAM select codes
  // ----------------------------------------------------------------
  localparam int SEL_RAM_MSB = 7;
  localparam int SEL_RAM_LSB = 6;
  localparam int SEL_IDX_MSB = 3;
  localparam int SEL_IDX_LSB = 0;
  localparam logic [1:0] RAM_COLOUR = 2'h0;
  localparam logic [1:0] RAM_OVERLAY = 2'h1;
  localparam logic [1:0] RAM_RSVD = 2'h2;
  localparam logic [1:0] RAM_ALPHA = 2'h3;

  // ----------------------------------------------------------------
  // Counts, phases and reset values
  // ----------------------------------------------------------------
  localparam int CTL_COUNT = 9;
  localparam int RAM_COUNT = 7;
  localparam int RAM_OVL_BASE = 3;
  localparam int RAM_ALPHA_IDX = 6;
  localparam logic [1:0] PHASE_RED = 2'h0;
  localparam logic [1:0] PHASE_BLUE = 2'h2;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] RSVD_READ = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'hff;
  localparam logic [7:0] ALPHA_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Host end sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MHP_IDLE = 2'b00,
    MHP_STROBE = 2'b01,
    MHP_HOLD = 2'b10
  } mhp_host_state_t;

endpackage

// ==== verilog/mhp_if.sv ====
// Eight-bit parallel link between host and mixer port
interface mhp_if;
  logic cs_n;
  logic rw;
  logic [2:0] addr;
  logic [7:0] host_data;
  logic host_oe;
  logic [7:0] dev_data;
  logic dev_oe;
  logic [7:0] d_bus;

  // Resolved data bus, pulled high when nobody drives
  assign d_bus = dev_oe ? dev_data : (host_oe ? host_data : mhp_pkg::BUS_IDLE);

  modport device (input cs_n, input rw, input addr, input d_bus,
                  output dev_data, output dev_oe);
  modport host (output cs_n, output rw, output addr, output host_data,
                output host_oe, input d_bus);
endinterface

// ==== verilog/mhp_lut_ram.sv ====
// One lookup RAM: clocked write, two asynchronous read ports
module mhp_lut_ram #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  // Clock and enable
  input wire logic i_clk,
  input wire logic i_ce,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Host read port
  input wire logic [AW-1:0] i_raddr_a,
  output logic [DW-1:0] o_rdata_a,
  // Pixel read port
  input wire logic [AW-1:0] i_raddr_b,
  output logic [DW-1:0] o_rdata_b
);
  logic [DW-1:0] mem [2**AW];

  // Storage write
  always_ff @(posedge i_clk)
  begin
    if (i_ce && i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Both reads are combinational; callers register the result
  assign o_rdata_a = mem[i_raddr_a];
  assign o_rdata_b = mem[i_raddr_b];
endmodule // mhp_lut_ram

// ==== verilog/mhp_device.sv ====
// Mixer host port: device end with control registers and lookup RAMs
//
// Functional notes
// - Port 000 loads write pointer, 011 read pointer
// - Port 001 transfers with RAM chosen by bits 7:6
// - Port 101 accesses control register at bits 3:0
// - Port 110 is pixel mask, host loads ones
// - Select bits 3:0 index nine control registers
// - Bits 7:6: colour, overlay, reserved, alpha table
// - Pointer auto-increments after each blue transfer or alpha read
// - Alpha writes pre-increment; host preloads one below the start address
// - Alpha reads return location, then increment
// - Colour locations take red, green, blue transfers
// - Host enables alpha table before reading it; here no enable bit gates reads, and the host end never sets one
// - Host enables colour tables before reading them; here no enable bit gates reads, and the host end never sets one
// - Table writes succeed whatever the enable bits
// - Read at 101 returns selected control register
// - Write at 101 stores into selected register
module mhp_device #(
  parameter int AW = 8
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Host link
  mhp_if.device link,
  // Pixel-side lookups
  input wire logic [AW-1:0] i_channel_a_pixel_input,
  input wire logic [AW-1:0] i_overlay_index,
  input wire logic [AW-1:0] i_alpha_index,
  output logic [23:0] o_colour_rgb,
  output logic [23:0] o_overlay_rgb,
  output logic [7:0] o_alpha_value,
  // Register contents for the datapath
  output logic [mhp_pkg::CTL_COUNT*8-1:0] o_ctl_regs,
  output logic [7:0] o_pixel_mask
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [1:0] wr_phase;
    logic [1:0] rd_phase;
    logic [7:0] sel;
    logic [7:0] mask;
    logic [mhp_pkg::CTL_COUNT-1:0][7:0] ctl;
    logic busy;
    logic oe;
    logic [7:0] dout;
    logic [23:0] colour;
    logic [23:0] overlay;
    logic [7:0] alpha;
  } mhp_dev_state_t;

  mhp_dev_state_t st_ff;
  mhp_dev_state_t nxt_st;

  logic take;
  logic [1:0] ram_sel;
  logic [3:0] ctl_idx;
  logic ctl_valid;
  logic [AW-1:0] ram_waddr;
  logic [mhp_pkg::RAM_COUNT-1:0] ram_we;
  logic [mhp_pkg::RAM_COUNT-1:0][7:0] ram_q;
  logic [mhp_pkg::RAM_COUNT-1:0][7:0] pix_q;
  logic [AW-1:0] pix_addr [mhp_pkg::RAM_COUNT];
  logic [7:0] ram_rdata;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // One access per chip-select assertion, taken on its first cycle
  assign take = ~link.cs_n & ~st_ff.busy;
  assign ram_sel = st_ff.sel[mhp_pkg::SEL_RAM_MSB:mhp_pkg::SEL_RAM_LSB];
  assign ctl_idx = st_ff.sel[mhp_pkg::SEL_IDX_MSB:mhp_pkg::SEL_IDX_LSB];
  assign ctl_valid = 32'(ctl_idx) < mhp_pkg::CTL_COUNT;
  // Alpha table stores one past the pointer
  assign ram_waddr = (ram_sel == mhp_pkg::RAM_ALPHA) ?
                     st_ff.wr_ptr + AW'(mhp_pkg::ALPHA_STEP) : st_ff.wr_ptr;

  // Which RAM a given select and colour phase lands in
  function automatic logic hit(input logic [1:0] s, input logic [1:0] ph, input int k);
    logic r;
    r = 1'b0;
    unique case (s)
      mhp_pkg::RAM_COLOUR: r = (k == 32'(ph));
      mhp_pkg::RAM_OVERLAY: r = (k == mhp_pkg::RAM_OVL_BASE + 32'(ph));
      mhp_pkg::RAM_ALPHA: r = (k == mhp_pkg::RAM_ALPHA_IDX);
      mhp_pkg::RAM_RSVD: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Lookup RAMs: colour r,g,b, overlay r,g,b, alpha
  // ----------------------------------------------------------------
  // Pixel addresses per RAM
  always_comb
  begin
    for (int k = 0; k < mhp_pkg::RAM_COUNT; k++)
    begin
      if (k < mhp_pkg::RAM_OVL_BASE)
        pix_addr[k] = i_channel_a_pixel_input & AW'(st_ff.mask);
      else if (k < mhp_pkg::RAM_ALPHA_IDX)
        pix_addr[k] = i_overlay_index;
      else
        pix_addr[k] = i_alpha_index;
    end
  end

  // Write enables ignore the use/bypass bits entirely
  always_comb
  begin
    for (int k = 0; k < mhp_pkg::RAM_COUNT; k++)
    begin
      ram_we[k] = i_ce & take & ~link.rw & (link.addr == mhp_pkg::PA_RAM_DATA)
                  & hit(ram_sel, st_ff.wr_phase, k);
    end
  end

  // Read data of the RAM that the read phase points at
  always_comb
  begin
    ram_rdata = mhp_pkg::RSVD_READ;
    for (int k = 0; k < mhp_pkg::RAM_COUNT; k++)
    begin
      if (hit(ram_sel, st_ff.rd_phase, k))
        ram_rdata = ram_q[k];
    end
  end

  for (genvar g = 0; g < mhp_pkg::RAM_COUNT; g++)
  begin : g_ram
    mhp_lut_ram #(
      .DW(8),
      .AW(AW)
    ) u_ram (
      .i_clk(i_clk),
      .i_ce(i_ce),
      .i_we(ram_we[g]),
      .i_waddr(ram_waddr),
      .i_wdata(link.d_bus),
      .i_raddr_a(st_ff.rd_ptr),
      .o_rdata_a(ram_q[g]),
      .i_raddr_b(pix_addr[g]),
      .o_rdata_b(pix_q[g])
    );
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.busy = ~link.cs_n;
    nxt_st.oe = 1'b0;
    // Pixel lookups registered every cycle
    nxt_st.colour = {pix_q[0], pix_q[1], pix_q[2]};
    nxt_st.overlay = {pix_q[3], pix_q[4], pix_q[5]};
    nxt_st.alpha = pix_q[mhp_pkg::RAM_ALPHA_IDX];
    if (take && !link.rw)
    begin
      // Host writes
      unique case (link.addr)
        mhp_pkg::PA_WR_PTR:
        begin
          nxt_st.wr_ptr = AW'(link.d_bus);
          nxt_st.wr_phase = mhp_pkg::PHASE_RED;
        end
        mhp_pkg::PA_RAM_DATA:
        begin
          unique case (ram_sel)
            mhp_pkg::RAM_COLOUR, mhp_pkg::RAM_OVERLAY:
            begin
              if (st_ff.wr_phase == mhp_pkg::PHASE_BLUE)
              begin
                nxt_st.wr_phase = mhp_pkg::PHASE_RED;
                nxt_st.wr_ptr = st_ff.wr_ptr + AW'(1);
              end
              else
                nxt_st.wr_phase = st_ff.wr_phase + 2'h1;
            end
            mhp_pkg::RAM_ALPHA: nxt_st.wr_ptr = ram_waddr;
            mhp_pkg::RAM_RSVD: nxt_st.wr_ptr = st_ff.wr_ptr;
          endcase
        end
        mhp_pkg::PA_RD_PTR:
        begin
          nxt_st.rd_ptr = AW'(link.d_bus);
          nxt_st.rd_phase = mhp_pkg::PHASE_RED;
        end
        mhp_pkg::PA_CTL_DATA:
        begin
          if (ctl_valid)
            nxt_st.ctl[ctl_idx] = link.d_bus;
        end
        mhp_pkg::PA_PIXEL_MASK: nxt_st.mask = link.d_bus;
        mhp_pkg::PA_INDIRECT_SEL: nxt_st.sel = link.d_bus;
        mhp_pkg::PA_RSVD_TWO, mhp_pkg::PA_RSVD_FOUR: nxt_st.sel = st_ff.sel;
      endcase
    end
    else if (take)
    begin
      // Host reads: data appears the next cycle
      nxt_st.oe = 1'b1;
      nxt_st.dout = mhp_pkg::RSVD_READ;
      unique case (link.addr)
        mhp_pkg::PA_RAM_DATA:
        begin
          nxt_st.dout = ram_rdata;
          unique case (ram_sel)
            mhp_pkg::RAM_COLOUR, mhp_pkg::RAM_OVERLAY:
            begin
              if (st_ff.rd_phase == mhp_pkg::PHASE_BLUE)
              begin
                nxt_st.rd_phase = mhp_pkg::PHASE_RED;
                nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
              end
              else
                nxt_st.rd_phase = st_ff.rd_phase + 2'h1;
            end
            mhp_pkg::RAM_ALPHA: nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
            mhp_pkg::RAM_RSVD: nxt_st.rd_ptr = st_ff.rd_ptr;
          endcase
        end
        mhp_pkg::PA_CTL_DATA:
        begin
          if (ctl_valid)
            nxt_st.dout = st_ff.ctl[ctl_idx];
        end
        mhp_pkg::PA_PIXEL_MASK: nxt_st.dout = st_ff.mask;
        mhp_pkg::PA_INDIRECT_SEL: nxt_st.dout = st_ff.sel;
        mhp_pkg::PA_WR_PTR, mhp_pkg::PA_RD_PTR,
        mhp_pkg::PA_RSVD_TWO, mhp_pkg::PA_RSVD_FOUR:
          nxt_st.dout = mhp_pkg::RSVD_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.busy <= 1'b1;
      st_ff.sel <= mhp_pkg::SEL_RESET;
      st_ff.mask <= mhp_pkg::MASK_RESET;
      st_ff.ctl <= {mhp_pkg::CTL_COUNT{mhp_pkg::CTL_RESET}};
    end
    else if (i_ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus released as soon as chip select drops
  assign link.dev_oe = st_ff.oe & ~link.cs_n;
  assign link.dev_data = st_ff.dout;
  assign o_colour_rgb = st_ff.colour;
  assign o_overlay_rgb = st_ff.overlay;
  assign o_alpha_value = st_ff.alpha;
  assign o_ctl_regs = st_ff.ctl;
  assign o_pixel_mask = st_ff.mask;

endmodule // mhp_device

// ==== verilog/mhp_host.sv ====
// Mixer host port: host end turning commands into bus cycles
module mhp_host (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Command port
  input wire logic i_cmd_valid,
  input wire logic i_cmd_rw,
  input wire logic [2:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_wdata,
  input wire logic i_cmd_alpha_preload,
  output logic o_cmd_ready,
  // Response port
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_rdata,
  output logic [1:0] o_colour_phase,
  // Device link
  mhp_if.host link
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mhp_pkg::mhp_host_state_t state;
    logic init_pending;
    logic cs_n;
    logic rw;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rsp_valid;
    logic [1:0] phase;
  } mhp_host_reg_t;

  mhp_host_reg_t st_ff;
  mhp_host_reg_t nxt_st;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = 1'b0;
    unique case (st_ff.state)
      mhp_pkg::MHP_IDLE:
      begin
        if (st_ff.init_pending)
        begin
          // First cycle after reset: open the pixel mask fully
          nxt_st.init_pending = 1'b0;
          nxt_st.cs_n = 1'b0;
          nxt_st.rw = 1'b0;
          nxt_st.addr = mhp_pkg::PA_PIXEL_MASK;
          nxt_st.wdata = mhp_pkg::MASK_RESET;
          nxt_st.state = mhp_pkg::MHP_STROBE;
        end
        else if (i_cmd_valid)
        begin
          nxt_st.cs_n = 1'b0;
          nxt_st.rw = i_cmd_rw;
          nxt_st.addr = i_cmd_addr;
          // Alpha writes pre-increment, so aim one below the start
          nxt_st.wdata = i_cmd_alpha_preload ?
                         i_cmd_wdata - mhp_pkg::ALPHA_STEP : i_cmd_wdata;
          nxt_st.state = mhp_pkg::MHP_STROBE;
          // Track red, green, blue position of table transfers
          if (i_cmd_addr == mhp_pkg::PA_WR_PTR || i_cmd_addr == mhp_pkg::PA_RD_PTR)
            nxt_st.phase = mhp_pkg::PHASE_RED;
          else if (i_cmd_addr == mhp_pkg::PA_RAM_DATA)
            nxt_st.phase = (st_ff.phase == mhp_pkg::PHASE_BLUE) ?
                           mhp_pkg::PHASE_RED : st_ff.phase + 2'h1;
        end
      end
      mhp_pkg::MHP_STROBE: nxt_st.state = mhp_pkg::MHP_HOLD;
      mhp_pkg::MHP_HOLD:
      begin
        // Device data is on the bus during this cycle
        nxt_st.rdata = st_ff.rw ? link.d_bus : st_ff.rdata;
        nxt_st.rsp_valid = 1'b1;
        nxt_st.cs_n = 1'b1;
        nxt_st.state = mhp_pkg::MHP_IDLE;
      end
      default: nxt_st.state = mhp_pkg::MHP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.state <= mhp_pkg::MHP_IDLE;
      st_ff.init_pending <= 1'b1;
      st_ff.cs_n <= 1'b1;
    end
    else if (i_ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_cmd_ready = (st_ff.state == mhp_pkg::MHP_IDLE) & ~st_ff.init_pending;
  assign o_rsp_valid = st_ff.rsp_valid;
  assign o_rsp_rdata = st_ff.rdata;
  assign o_colour_phase = st_ff.phase;
  assign link.cs_n = st_ff.cs_n;
  assign link.rw = st_ff.rw;
  assign link.addr = st_ff.addr;
  assign link.host_data = st_ff.wdata;
  assign link.host_oe = ~st_ff.cs_n & ~st_ff.rw;

endmodule // mhp_host

// ==== dv/mhp_monitor.sv ====
// Checker of the parallel link between host end and device end
module mhp_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Link signals
  input wire logic cs_n,
  input wire logic rw,
  input wire logic [2:0] addr,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_oe,
  input wire logic [7:0] d_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Access steps
  // ----------------------------------------------------------------
  sequence read_take_s;
    $fell(cs_n) && rw;
  endsequence

  sequence strobe_end_s;
    !cs_n ##1 cs_n;
  endsequence

  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  read_answer_a: assert property (read_take_s |=> dev_oe && !cs_n)
    else $error("device gave no read data after a read strobe");
  strobe_len_a: assert property ($fell(cs_n) |=> strobe_end_s)
    else $error("chip select low for a wrong number of cycles");
  oe_select_a: assert property (dev_oe |-> !cs_n && rw)
    else $error("device drives the bus outside a selected read");
  no_fight_a: assert property (!(dev_oe && host_oe))
    else $error("host and device drive the bus together");
  rsvd_read_a: assert property (dev_oe && addr inside {3'h0, 3'h2, 3'h3, 3'h4}
    |-> dev_data == 8'h00)
    else $error("reserved or write-only port read is not zero");
  host_drive_a: assert property (host_oe |-> !cs_n && !rw && d_bus == host_data)
    else $error("host drives the bus outside a write");
  mask_init_a: assert property ($fell(i_rst) |-> ##[1:5]
    (!cs_n && !rw && addr == 3'h6 && d_bus == 8'hff))
    else $error("mask not loaded with all ones after reset");
  bus_release_a: assert property ($rose(cs_n) |-> !dev_oe && !host_oe)
    else $error("bus still driven after deselect");
endmodule // mhp_monitor

// ==== dv/test_mixer_host_port_lut_access.sv ====
// Testbench joining host end and device end of the mixer host port
module test_mixer_host_port_lut_access;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk, i_rst, i_ce;
  logic i_cmd_valid, i_cmd_rw, i_cmd_alpha_preload;
  logic [2:0] i_cmd_addr;
  logic [7:0] i_cmd_wdata, o_rsp_rdata, o_alpha_value, o_pixel_mask, rd;
  logic o_cmd_ready, o_rsp_valid;
  logic [1:0] o_colour_phase;
  logic [7:0] i_pix, i_ovl, i_alp;
  logic [23:0] o_colour_rgb, o_overlay_rgb;
  logic [71:0] o_ctl_regs;
  int err_total, checks_done, cyc;
  // Rows: flags nibble (bit0 read, bit1 preload), port nibble, data or expected read
  logic [15:0] rows [$] = '{
    16'h0702, 16'h05a5, 16'h15a5, 16'h0707, 16'h055a, 16'h155a, 16'h1707,
    16'h0709, 16'h053c, 16'h1500, 16'h0211, 16'h1200, 16'h1400, 16'h1000, 16'h1300,
    16'h16ff, 16'h060f, 16'h160f, 16'h06ff,
    16'h0700, 16'h0010, 16'h0111, 16'h0122, 16'h0133, 16'h0144, 16'h0155, 16'h0166,
    16'h0510, 16'h0310, 16'h1111, 16'h1122, 16'h1133, 16'h1144, 16'h1155, 16'h1166,
    16'h0740, 16'h0005, 16'h01a1, 16'h01a2, 16'h01a3, 16'h0305, 16'h11a1, 16'h11a2,
    16'h11a3, 16'h07c6, 16'h2000, 16'h0177, 16'h0188, 16'h0780, 16'h0199, 16'h1100,
    16'h07c6, 16'h01bb, 16'h0520, 16'h0300, 16'h1177, 16'h1188, 16'h11bb};

  // ----------------------------------------------------------------
  // Two ends joined by the link, checker beside it
  // ----------------------------------------------------------------
  mhp_if bus();
  mhp_device mhp_device_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .link(bus.device),
    .i_channel_a_pixel_input(i_pix), .i_overlay_index(i_ovl), .i_alpha_index(i_alp),
    .o_colour_rgb(o_colour_rgb), .o_overlay_rgb(o_overlay_rgb),
    .o_alpha_value(o_alpha_value), .o_ctl_regs(o_ctl_regs), .o_pixel_mask(o_pixel_mask));
  mhp_host mhp_host_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_cmd_valid(i_cmd_valid), .i_cmd_rw(i_cmd_rw), .i_cmd_addr(i_cmd_addr),
    .i_cmd_wdata(i_cmd_wdata), .i_cmd_alpha_preload(i_cmd_alpha_preload),
    .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
    .o_colour_phase(o_colour_phase), .link(bus.host));
  mhp_monitor mhp_monitor_inst (.i_clk(i_clk), .i_rst(i_rst), .cs_n(bus.cs_n), .rw(bus.rw),
    .addr(bus.addr), .host_data(bus.host_data), .host_oe(bus.host_oe),
    .dev_data(bus.dev_data), .dev_oe(bus.dev_oe), .d_bus(bus.d_bus));

  // ----------------------------------------------------------------
  // Clock, hang limit and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Cut a hang short
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command through the host end, entered at a falling edge
  task automatic cmd(input logic [15:0] r, output logic [7:0] rdata);
    int n;
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge i_clk);
      n++;
    end
    i_cmd_valid = 1'b1;
    i_cmd_rw = r[12];
    i_cmd_alpha_preload = r[13];
    i_cmd_addr = r[10:8];
    i_cmd_wdata = r[7:0];
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    n = 0;
    while (o_rsp_valid !== 1'b1 && n < 10)
    begin
      @(negedge i_clk);
      n++;
    end
    check(72'(o_rsp_valid), 72'h1);
    rdata = o_rsp_rdata;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {err_total, checks_done, cyc} = '0;
    {i_rst, i_ce, i_cmd_valid, i_cmd_rw, i_cmd_alpha_preload} = 5'b11000;
    {i_cmd_addr, i_cmd_wdata, i_pix, i_ovl, i_alp} = {3'h0, 8'h00, 8'h1f, 8'h05, 8'h01};
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    foreach (rows[k])
    begin
      cmd(rows[k], rd);
      if (rows[k][12])
        check(72'(rd), 72'(rows[k][7:0]));
    end
    $display("table rows done");
    // Masked pixel 1f becomes 10; overlay and alpha lookups
    cmd(16'h06f0, rd);
    repeat (3) @(negedge i_clk);
    check(72'(o_colour_rgb), 72'h112233);
    check(72'(o_overlay_rgb), 72'ha1a2a3);
    check(72'(o_alpha_value), 72'h88);
    check(72'(o_pixel_mask), 72'hf0);
    check(72'(o_ctl_regs[23:16]), 72'ha5);
    check(72'(o_ctl_regs[55:48]), 72'h20);
    check(72'(o_ctl_regs[63:56]), 72'h5a);
    check(72'(o_ctl_regs[7:0]), 72'h10);
    // One more table transfer moves the host's colour phase on
    cmd(16'h0122, rd);
    check(72'(o_colour_phase), 72'h1);
    $display("lookup test done");
    // Reset in mid-run clears control registers, sets the mask to all ones and frees the bus
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    check(o_ctl_regs, 72'h0);
    check(72'(o_pixel_mask), 72'hff);
    check(72'({bus.cs_n, bus.dev_oe}), 72'h2);
    i_rst = 1'b0;
    cmd(16'h1500, rd);
    check(72'(rd), 72'h00);
    cmd(16'h16ff, rd);
    check(72'(rd), 72'hff);
    $display("reset test done");
    // Clock enable low holds a pending command and all state
    i_ce = 1'b0;
    {i_cmd_valid, i_cmd_rw, i_cmd_alpha_preload} = 3'h4;
    {i_cmd_addr, i_cmd_wdata} = {3'h6, 8'h0f};
    repeat (3) @(negedge i_clk);
    check(72'({o_cmd_ready, bus.cs_n, o_pixel_mask}), 72'h3ff);
    i_ce = 1'b1;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    repeat (3) @(negedge i_clk);
    check(72'(o_pixel_mask), 72'h0f);
    $display("enable test done");
    end_sim();
  end
endmodule // test_mixer_host_port_lut_access
